// [design/bsa_top.sv]
/*
 * Transfer-buffer scratchpad access: buffer address registers, the
 * graphics-pipeline request path with its line buffer, and the special
 * instruction path to internal registers.
 * Assumes the core issues at most one instruction per cycle and the cache
 * array answers reads combinationally on the cycle it is addressed.
 */
`timescale 1ns/1ps

module bsa_top #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration
  input wire logic [7:0] graphics_config_register,
  input wire logic graphics_config_we,
  output logic [1:0] scratchpad_size_field,
  output logic tag_lock,
  output logic scratchpad_lines_valid,
  output logic scratchpad_no_flush,
  // Instruction path from the core
  input wire logic instr_valid,
  input wire bsa_pkg::bsa_instr_s instr,
  output logic instr_done,
  output logic illegal_opcode_trap,
  output logic [31:0] acc_result,
  output logic acc_result_valid,
  // Special I/O transaction
  output logic io_special_valid,
  output logic [31:0] io_special_addr,
  output logic io_special_write,
  // Graphics pipeline
  input wire logic gp_req_valid,
  input wire bsa_pkg::bsa_gp_req_s gp_req,
  output logic gp_req_ready,
  output logic [DATA_W-1:0] gp_rdata,
  output logic gp_rdata_valid,
  input wire logic gp_reload,
  input wire logic gp_reload_sel,
  // Cache array port for set 0
  output logic cache_valid,
  output logic cache_write,
  output logic [bsa_pkg::ADDR_W-1:0] cache_addr,
  output logic [127:0] cache_wline,
  output logic [15:0] cache_wbe,
  input wire logic [127:0] cache_rline
);

  if (DATA_W != 32) begin : g_bad_width
    $error("bsa_top serves 32-bit requests only");
  end

  // ****************************************************************
  // Configuration and instruction decode
  // ****************************************************************
  logic [1:0] sp_size_reg;
  logic sp_enabled;
  logic is_gfx_op;
  logic op_rl0;
  logic op_rl1;
  logic op_wr;
  logic op_rd;

  // Only the size field is held here; the memory base bits live elsewhere.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_size_reg <= bsa_pkg::GCR_RESET[bsa_pkg::SP_LSB +: 2];
    end else if (graphics_config_we) begin
      sp_size_reg <= graphics_config_register[bsa_pkg::SP_LSB +: 2];
    end
  end

  assign sp_enabled = (sp_size_reg != bsa_pkg::SP_NONE);
  assign scratchpad_size_field = sp_size_reg;
  assign tag_lock = sp_enabled;
  assign scratchpad_lines_valid = sp_enabled;
  assign scratchpad_no_flush = sp_enabled;

  // Only the four graphics opcodes are ours; all others pass by untouched.
  always_comb begin
    is_gfx_op = 1'b0;
    op_rl0 = 1'b0;
    op_rl1 = 1'b0;
    op_wr = 1'b0;
    op_rd = 1'b0;
    if (instr_valid) begin
      case (instr.opcode)
        bsa_pkg::OP_BUF0_RELOAD: begin
          is_gfx_op = 1'b1;
          op_rl0 = sp_enabled;
        end
        bsa_pkg::OP_BUF1_RELOAD: begin
          is_gfx_op = 1'b1;
          op_rl1 = sp_enabled;
        end
        bsa_pkg::OP_REG_WRITE: begin
          is_gfx_op = 1'b1;
          op_wr = sp_enabled;
        end
        bsa_pkg::OP_REG_READ: begin
          is_gfx_op = 1'b1;
          op_rd = sp_enabled;
        end
        default: begin
          is_gfx_op = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Instruction answers
  // ****************************************************************
  // A disabled scratchpad turns every graphics opcode into a trap, so
  // software probing for the opcodes still sees the trap it expects.
  logic trap_reg;
  logic done_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trap_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      trap_reg <= is_gfx_op && !sp_enabled;
      done_reg <= is_gfx_op && sp_enabled;
    end
  end

  assign illegal_opcode_trap = trap_reg;
  assign instr_done = done_reg;

  // The register access is flagged on the internal I/O cycle.
  logic io_valid_reg;
  logic io_write_reg;
  logic [31:0] io_addr_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_valid_reg <= 1'b0;
      io_write_reg <= 1'b0;
      io_addr_reg <= 32'h0000_0000;
    end else begin
      io_valid_reg <= op_wr || op_rd;
      io_write_reg <= op_wr;
      if (op_wr || op_rd) begin
        io_addr_reg <= instr.base_gpr;
        io_addr_reg[bsa_pkg::IO_SPECIAL_BIT] <= 1'b1;
      end
    end
  end

  assign io_special_valid = io_valid_reg;
  assign io_special_write = io_write_reg;
  assign io_special_addr = io_addr_reg;

  // ****************************************************************
  // Internal registers
  // ****************************************************************
  logic [15:0] base_reg [2];
  logic [15:0] ptr_reg [2];
  logic [31:0] power_manage_base_address_reg;
  logic [31:0] power_manage_address_mask_reg;
  logic [1:0] hit_base;
  logic [1:0] hit_ptr;
  logic hit_power_manage_base_address;
  logic hit_power_manage_address_mask;
  logic line_wrap;
  logic [1:0] adv;
  logic [1:0] rld;
  logic gp_take;

  // Addresses are compared in all 32 bits, so an alias that differs only
  // in the top nibble is not a hit.
  assign hit_base[0] = instr.base_gpr == bsa_pkg::ADDR_BUF0_BASE;
  assign hit_base[1] = instr.base_gpr == bsa_pkg::ADDR_BUF1_BASE;
  assign hit_ptr[0] = instr.base_gpr == bsa_pkg::ADDR_BUF0_PTR;
  assign hit_ptr[1] = instr.base_gpr == bsa_pkg::ADDR_BUF1_PTR;
  assign hit_power_manage_base_address = instr.base_gpr == bsa_pkg::ADDR_POWER_MANAGE_BASE_ADDRESS;
  assign hit_power_manage_address_mask = instr.base_gpr == bsa_pkg::ADDR_POWER_MANAGE_ADDRESS_MASK;

  // Base and pointer storage has no reset; software loads it first.
  for (genvar i = 0; i < 2; i++) begin : g_buf
    assign adv[i] = gp_take && (gp_req.buf_sel == 1'(i));
    assign rld[i] = (gp_reload && (gp_reload_sel == 1'(i))) ||
      (i == 0 ? op_rl0 : op_rl1);

    always_ff @(posedge core_clk) begin
      if (op_wr && hit_base[i]) begin
        base_reg[i] <= instr.acc[15:0] & bsa_pkg::BASE_MASK;
      end
    end

    // A reload wins over a same-cycle advance and software write.
    always_ff @(posedge core_clk) begin
      if (rld[i]) begin
        ptr_reg[i] <= base_reg[i] & bsa_pkg::PTR_MASK;
      end else if (op_wr && hit_ptr[i]) begin
        ptr_reg[i] <= instr.acc[15:0] & bsa_pkg::PTR_MASK;
      end else if (adv[i] && line_wrap) begin
        ptr_reg[i][bsa_pkg::LINE_MSB:bsa_pkg::LINE_LSB] <=
          ptr_reg[i][bsa_pkg::LINE_MSB:bsa_pkg::LINE_LSB] + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Power management registers
  // ****************************************************************
  // Their meaning belongs to another block; here they are plain storage.
  always_ff @(posedge core_clk) begin
    if (op_wr && hit_power_manage_base_address) begin
      power_manage_base_address_reg <= instr.acc;
    end
    if (op_wr && hit_power_manage_address_mask) begin
      power_manage_address_mask_reg <= instr.acc;
    end
  end

  logic [31:0] rd_mux;
  logic [31:0] acc_reg;
  logic acc_valid_reg;

  // Unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_base[0]) begin
      rd_mux = {16'h0000, base_reg[0] & bsa_pkg::BASE_MASK};
    end else if (hit_base[1]) begin
      rd_mux = {16'h0000, base_reg[1] & bsa_pkg::BASE_MASK};
    end else if (hit_ptr[0]) begin
      rd_mux = {16'h0000, ptr_reg[0] & bsa_pkg::PTR_MASK};
    end else if (hit_ptr[1]) begin
      rd_mux = {16'h0000, ptr_reg[1] & bsa_pkg::PTR_MASK};
    end else if (hit_power_manage_base_address) begin
      rd_mux = power_manage_base_address_reg;
    end else if (hit_power_manage_address_mask) begin
      rd_mux = power_manage_address_mask_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_reg <= 32'h0000_0000;
      acc_valid_reg <= 1'b0;
    end else begin
      acc_valid_reg <= op_rd;
      if (op_rd) begin
        acc_reg <= rd_mux;
      end
    end
  end

  assign acc_result = acc_reg;
  assign acc_result_valid = acc_valid_reg;

  // ****************************************************************
  // Graphics pipeline requests and line buffer
  // ****************************************************************
  // Each request covers one 32-bit word; the byte offset runs from the
  // base's starting byte and the line index comes from the pointer.
  logic [bsa_pkg::BYTE_W-1:0] byte_ofs_reg [2];
  logic [bsa_pkg::BYTE_W-1:0] cur_byte;
  logic [bsa_pkg::LINE_W-1:0] cur_line;
  logic [3:0] lane_byte;
  logic [6:0] lane_bit;
  bsa_pkg::bsa_sp_addr_s req_addr;
  logic lb_valid_reg;
  logic [bsa_pkg::LINE_W-1:0] lb_line_reg;
  logic [127:0] lb_data_reg;
  logic lb_hit;
  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg;

  assign gp_req_ready = sp_enabled;
  assign gp_take = gp_req_valid && gp_req_ready;
  assign cur_byte = byte_ofs_reg[gp_req.buf_sel];
  assign cur_line = ptr_reg[gp_req.buf_sel]
    [bsa_pkg::LINE_MSB:bsa_pkg::LINE_LSB];
  assign req_addr = '{line: cur_line, byte_ofs: cur_byte};
  // Once the next word would start past the last byte of the line, the
  // pointer moves on to the following line.
  assign line_wrap = (cur_byte > 4'(bsa_pkg::LINE_BYTES - 4 - 1));
  assign lane_byte = {cur_byte[3:2], 2'h0};
  assign lane_bit = {cur_byte[3:2], 5'h00};

  for (genvar j = 0; j < 2; j++) begin : g_ofs
    always_ff @(posedge core_clk) begin
      if (rld[j]) begin
        byte_ofs_reg[j] <= base_reg[j][bsa_pkg::BYTE_W-1:0];
      end else if (op_wr && hit_base[j]) begin
        byte_ofs_reg[j] <= instr.acc[bsa_pkg::BYTE_W-1:0];
      end else if (adv[j]) begin
        byte_ofs_reg[j] <= cur_byte + 4'h4;
      end
    end
  end

  // Reads hit in the line buffer skip the cache array entirely.
  assign lb_hit = lb_valid_reg && lb_line_reg == cur_line;
  assign cache_valid = gp_take && (gp_req.write || !lb_hit);
  assign cache_write = gp_take && gp_req.write;
  assign cache_addr = {req_addr.line, req_addr.byte_ofs};
  assign cache_wline = {4{gp_req.wdata}};
  // Byte enables follow the word lane, so writes and reads meet one lane.
  assign cache_wbe = 16'h000f << lane_byte;

  // Any register write or reload may move the buffers, so the held line is
  // dropped rather than compared.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lb_valid_reg <= 1'b0;
      lb_line_reg <= '0;
      lb_data_reg <= '0;
    end else if (rld != 2'b00 || op_wr) begin
      lb_valid_reg <= 1'b0;
    end else if (gp_take && !gp_req.write && !lb_hit) begin
      lb_valid_reg <= 1'b1;
      lb_line_reg <= cur_line;
      lb_data_reg <= cache_rline;
    end else if (gp_take && gp_req.write && lb_hit) begin
      lb_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= gp_take && !gp_req.write;
      // Hits read the held line; misses read the array directly.
      if (gp_take && !gp_req.write) begin
        rdata_reg <= lb_hit ?
          lb_data_reg[lane_bit +: 32] :
          cache_rline[lane_bit +: 32];
      end
    end
  end

  assign gp_rdata = rdata_reg;
  assign gp_rdata_valid = rvalid_reg;

endmodule

// [design/bsa_pkg.sv]
/*
 * Package for the transfer-buffer scratchpad access block: internal register
 * addresses, field layouts, opcodes and carrier structs.
 * Assumes a single core clock domain and a synchronous active-high reset.
 */
//
// Behaviour
// - Nonzero scratchpad size locks the tags.
// - 32-bit buffer request maps to scratchpad location.
// - Accessed buffer pointer advances after each access; here the byte offset steps by 4 each access, the pointer line only at line end.
// - End-of-transfer reload copies base into pointer.
// - Sixteen-byte line buffer fronts cache for transfers.
// - Buffer registers unreset; software loads them first.
// - Base: 15:12 reserved, 11:4 line, 3:0 byte.
// - Pointer: line in 11:4, other bits zero.
// - Zero size traps all four graphics opcodes.
// - Opcodes 0F3A/0F3B reload pointer zero/one.
// - 0F3C writes, 0F3D reads internal register, 32 bits.
// - Internal access uses I/O cycle with top bit.
// - Base registers at FFFFF0Ch and FFFFFF1Ch.
// - Pointer registers at FFFFFF2Ch and FFFFF3Ch.
// - Power registers at FFFFF6Ch and FFFFFF7Ch.
// - Buffer base carries twelve address bits.
// - Size 00 none, 01 2K, 10 3K, 11 4K.
// - Enabled scratchpad lines always valid, never flushed.
package bsa_pkg;

  // ****************************************************************
  // Internal register addresses
  // ****************************************************************
  localparam logic [31:0] ADDR_BUF0_BASE = 32'h0fff_ff0c;
  localparam logic [31:0] ADDR_BUF1_BASE = 32'hffff_ff1c;
  localparam logic [31:0] ADDR_BUF0_PTR = 32'hffff_ff2c;
  localparam logic [31:0] ADDR_BUF1_PTR = 32'h0fff_ff3c;
  localparam logic [31:0] ADDR_POWER_MANAGE_BASE_ADDRESS = 32'h0fff_ff6c;
  localparam logic [31:0] ADDR_POWER_MANAGE_ADDRESS_MASK = 32'hffff_ff7c;
  localparam int IO_SPECIAL_BIT = 31;

  // ****************************************************************
  // Field layout of the buffer registers
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int LINE_LSB = 4;
  localparam int LINE_MSB = 11;
  localparam int LINE_W = 8;
  localparam int BYTE_W = 4;
  localparam int LINE_BYTES = 16;
  localparam logic [15:0] BASE_MASK = 16'h0fff;
  localparam logic [15:0] PTR_MASK = 16'h0ff0;

  // ****************************************************************
  // Scratchpad size field
  // ****************************************************************
  localparam logic [1:0] SP_NONE = 2'h0;
  localparam logic [1:0] SP_2K = 2'h1;
  localparam logic [1:0] SP_3K = 2'h2;
  localparam logic [1:0] SP_4K = 2'h3;
  localparam int SP_LSB = 2;
  localparam logic [7:0] GCR_RESET = 8'h00;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [15:0] OP_BUF0_RELOAD = 16'h0f3a;
  localparam logic [15:0] OP_BUF1_RELOAD = 16'h0f3b;
  localparam logic [15:0] OP_REG_WRITE = 16'h0f3c;
  localparam logic [15:0] OP_REG_READ = 16'h0f3d;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] opcode;
    logic [31:0] base_gpr;
    logic [31:0] acc;
  } bsa_instr_s;

  typedef struct packed {
    logic buf_sel;
    logic write;
    logic [31:0] wdata;
  } bsa_gp_req_s;

  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [BYTE_W-1:0] byte_ofs;
  } bsa_sp_addr_s;

endpackage

// [test/bsa_top_sva.sv]
/* Assertion checker for bsa_top, bound to every instance.
   Assumes one core clock and the synchronous reset srst. */
`timescale 1ns/1ps
module bsa_top_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration
  input wire logic [7:0] graphics_config_register,
  input wire logic graphics_config_we,
  input wire logic [1:0] scratchpad_size_field,
  input wire logic tag_lock,
  input wire logic scratchpad_lines_valid,
  input wire logic scratchpad_no_flush,
  // Instructions
  input wire logic instr_valid,
  input wire bsa_pkg::bsa_instr_s instr,
  input wire logic instr_done,
  input wire logic illegal_opcode_trap,
  input wire logic io_special_valid,
  input wire logic [31:0] io_special_addr,
  input wire logic io_special_write,
  // Graphics pipeline
  input wire logic gp_req_valid,
  input wire bsa_pkg::bsa_gp_req_s gp_req,
  input wire logic gp_req_ready,
  input wire logic gp_rdata_valid,
  input wire logic cache_valid,
  input wire logic cache_write
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic gfx;
  logic xfer;
  logic on;
  logic gp_go;
  assign gfx = instr_valid && instr.opcode >= bsa_pkg::OP_BUF0_RELOAD
    && instr.opcode <= bsa_pkg::OP_REG_READ;
  assign xfer = gfx && instr.opcode >= bsa_pkg::OP_REG_WRITE;
  assign on = scratchpad_size_field != 2'h0;
  assign gp_go = gp_req_valid && gp_req_ready;

  // ********
  // Checks
  // ********
  a_trap_off:
    assert property (gfx && !on |=> illegal_opcode_trap && !instr_done)
    else $error("graphics op not trapped");
  a_done_on:
    assert property (gfx && on |=> instr_done && !illegal_opcode_trap)
    else $error("graphics op not completed");
  a_io_top_bit:
    assert property (io_special_valid |-> io_special_addr[31])
    else $error("special cycle without top bit");
  a_io_addr_copy:
    assert property (xfer && on |=> io_special_valid &&
      io_special_addr == ($past(instr.base_gpr) | 32'h8000_0000))
    else $error("special cycle address wrong");
  a_io_dir:
    assert property (xfer && on |=> io_special_write ==
      ($past(instr.opcode) == bsa_pkg::OP_REG_WRITE))
    else $error("special cycle direction wrong");
  a_io_quiet:
    assert property (!(xfer && on) |=> !io_special_valid)
    else $error("special cycle without register access");
  a_size_load:
    assert property (graphics_config_we |=> scratchpad_size_field ==
      $past(graphics_config_register[3:2]))
    else $error("size field not loaded");
  a_tag_lock:
    assert property (tag_lock == on)
    else $error("tag lock level wrong");
  a_lines_kept:
    assert property (scratchpad_lines_valid == on
      && scratchpad_no_flush == on)
    else $error("scratchpad line state wrong");
  a_gp_answer:
    assert property (gp_go && !gp_req.write |=> gp_rdata_valid)
    else $error("buffer read not answered");
  a_gp_write_thru:
    assert property (gp_go && gp_req.write |-> cache_valid && cache_write)
    else $error("buffer write not passed on");
  c_trap: cover property (gfx && !on);
  c_xfer: cover property (xfer && on);
  c_gp_read: cover property (gp_go && !gp_req.write);
endmodule

bind bsa_top bsa_top_sva u_sva (.*);

// [test/bsa_cache_model.sv]
/* Behavioural set-0 cache array beside bsa_top.
   Assumes the block addresses it as {line, byte} with byte enables. */
`timescale 1ns/1ps
module bsa_cache_model (
  // Clock
  input wire logic core_clk,
  // Array port
  input wire logic cache_valid,
  input wire logic cache_write,
  input wire logic [11:0] cache_addr,
  input wire logic [127:0] cache_wline,
  input wire logic [15:0] cache_wbe,
  output logic [127:0] cache_rline
);
  // Every line is scratchpad, with no valid bit to lose.
  logic [127:0] mem [256];
  logic [127:0] junk = {8{16'ha5c3}};
  always @(posedge core_clk) begin
    junk <= ~junk;
    if (cache_valid && cache_write) begin
      for (int b = 0; b < 16; b++) begin
        if (cache_wbe[b]) begin
          mem[cache_addr[11:4]][b*8 +: 8] <= cache_wline[b*8 +: 8];
        end
      end
    end
  end
  // An unselected port shows a pattern that changes every cycle.
  assign cache_rline = (cache_valid && !cache_write) ?
    mem[cache_addr[11:4]] : junk;
endmodule

// [test/bsa_top_tb_top.sv]
/* Self-checking bench for bsa_top with the cache array model.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
module bsa_top_tb_top;
  typedef struct packed {logic [31:0] a, d, e;} bsa_row_s;
  logic core_clk, srst, graphics_config_we, instr_valid, gp_req_valid;
  logic gp_reload, gp_reload_sel, tag_lock, scratchpad_lines_valid;
  logic scratchpad_no_flush, instr_done, illegal_opcode_trap;
  logic acc_result_valid, io_special_valid, io_special_write;
  logic gp_req_ready, gp_rdata_valid, cache_valid, cache_write;
  logic [7:0] graphics_config_register;
  logic [1:0] scratchpad_size_field;
  logic [31:0] acc_result, io_special_addr, gp_rdata;
  logic [11:0] cache_addr;
  logic [127:0] cache_wline, cache_rline;
  logic [15:0] cache_wbe;
  bsa_pkg::bsa_instr_s instr;
  bsa_pkg::bsa_gp_req_s gp_req;
  bsa_row_s rows [8];
  int err_total, n_checks;

  bsa_top u_dut (.*);
  bsa_cache_model u_cache (.*);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string w, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkb(input string w, input logic e, g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic ins(input logic [15:0] op, input logic [31:0] g, d);
    @(negedge core_clk);
    instr_valid = 1'h1;
    instr = '{op, g, d};
    @(negedge core_clk);
    instr_valid = 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    ins(bsa_pkg::OP_REG_READ, a, 32'h0);
    chk("acc_result", e, acc_result);
    chkb("acc_valid", 1'h1, acc_result_valid);
  endtask
  task automatic gp(input logic s, w, input logic [31:0] d,
                    input logic [11:0] a, input logic cv);
    @(negedge core_clk);
    gp_req_valid = 1'h1;
    gp_req = '{s, w, d};
    #1;
    if (cv) chk("cache_addr", {20'h0, a}, {20'h0, cache_addr});
    chkb("cache_valid", cv, cache_valid);
    if (w) chk("cache_wbe", {16'h0, 16'h000f << {a[3:2], 2'h0}},
               {16'h0, cache_wbe});
    if (w) chk("cache_wline", d, cache_wline[{a[3:2], 5'h00} +: 32]);
    @(negedge core_clk);
    gp_req_valid = 1'h0;
    chkb("rvalid", !w, gp_rdata_valid);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    srst = 1'h1;
    {graphics_config_we, instr_valid, gp_req_valid} = 3'h0;
    {gp_reload, gp_reload_sel} = 2'h0;
    graphics_config_register = 8'h00;
    instr = '0;
    gp_req = '0;
    rows[0] = '{bsa_pkg::ADDR_BUF0_BASE, 32'hffff_ffff, 32'h0000_0fff};
    rows[1] = '{bsa_pkg::ADDR_BUF1_BASE, 32'h1234_5abc, 32'h0000_0abc};
    rows[2] = '{bsa_pkg::ADDR_BUF0_PTR, 32'hffff_ffff, 32'h0000_0ff0};
    rows[3] = '{bsa_pkg::ADDR_BUF1_PTR, 32'h0000_f00f, 32'h0000_0000};
    rows[4] = '{bsa_pkg::ADDR_POWER_MANAGE_BASE_ADDRESS, 32'h8765_4321, 32'h8765_4321};
    rows[5] = '{bsa_pkg::ADDR_POWER_MANAGE_ADDRESS_MASK, 32'hffff_0000, 32'hffff_0000};
    rows[6] = '{32'hffff_ff4c, 32'h5a5a_5a5a, 32'h0000_0000};
    rows[7] = '{32'hffff_ff0c, 32'h0000_0111, 32'h0000_0000};
    repeat (3) @(negedge core_clk);
    srst = 1'h0;
    chk("size", 32'h0, {30'h0, scratchpad_size_field});
    chkb("lock", 1'h0, tag_lock);
    for (int k = 0; k < 4; k++) begin
      ins(16'h0f3a + 16'(k), 32'h0, 32'h0);
      chkb("trap", 1'h1, illegal_opcode_trap);
    end
    for (int s = 0; s < 4; s++) begin
      @(negedge core_clk);
      graphics_config_register = {4'h0, s[1:0], 2'h0};
      graphics_config_we = 1'h1;
      @(negedge core_clk);
      graphics_config_we = 1'h0;
      chk("size", 32'(s), {30'h0, scratchpad_size_field});
      chkb("lock", s != 0, tag_lock);
      chkb("no_flush", s != 0, scratchpad_no_flush);
      chkb("lines_valid", s != 0, scratchpad_lines_valid);
      chkb("ready", s != 0, gp_req_ready);
      ins(bsa_pkg::OP_BUF1_RELOAD, 32'h0, 32'h0);
      chkb("trap", s == 0, illegal_opcode_trap);
      chkb("done", s != 0, instr_done);
    end
    foreach (rows[i]) begin
      ins(bsa_pkg::OP_REG_WRITE, rows[i].a, rows[i].d);
      chkb("io_write", 1'h1, io_special_write);
    end
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].e);
      chk("io_addr", rows[i].a | 32'h8000_0000, io_special_addr);
      chkb("io_valid", 1'h1, io_special_valid);
      chkb("io_write", 1'h0, io_special_write);
    end
    ins(bsa_pkg::OP_REG_WRITE, bsa_pkg::ADDR_BUF0_BASE, 32'h0000_0128);
    ins(bsa_pkg::OP_BUF0_RELOAD, 32'h0, 32'h0);
    rd(bsa_pkg::ADDR_BUF0_PTR, 32'h0000_0120);
    ins(bsa_pkg::OP_BUF1_RELOAD, 32'h0, 32'h0);
    rd(bsa_pkg::ADDR_BUF1_PTR, 32'h0000_0ab0);
    for (int k = 0; k < 3; k++) begin
      gp(1'h0, 1'h1, 32'hc0de_0000 + 32'(k),
         12'h128 + 12'(4 * k), 1'h1);
    end
    rd(bsa_pkg::ADDR_BUF0_PTR, 32'h0000_0130);
    rd(bsa_pkg::ADDR_BUF1_PTR, 32'h0000_0ab0);
    @(negedge core_clk);
    gp_reload = 1'h1;
    @(negedge core_clk);
    gp_reload = 1'h0;
    rd(bsa_pkg::ADDR_BUF0_PTR, 32'h0000_0120);
    gp(1'h0, 1'h0, 32'h0, 12'h128, 1'h1);
    chk("gp_rdata", 32'hc0de_0000, gp_rdata);
    gp(1'h0, 1'h0, 32'h0, 12'h12c, 1'h0);
    chk("gp_rdata", 32'hc0de_0001, gp_rdata);
    gp(1'h1, 1'h0, 32'h0, 12'habc, 1'h1);
    rd(bsa_pkg::ADDR_BUF0_PTR, 32'h0000_0130);
    rd(bsa_pkg::ADDR_BUF1_PTR, 32'h0000_0ac0);
    // A reset in mid-run clears the size, so the opcodes trap again.
    @(negedge core_clk);
    srst = 1'h1;
    repeat (3) @(negedge core_clk);
    srst = 1'h0;
    chk("size", 32'h0, {30'h0, scratchpad_size_field});
    chkb("ready", 1'h0, gp_req_ready);
    chkb("lock", 1'h0, tag_lock);
    ins(bsa_pkg::OP_REG_READ, bsa_pkg::ADDR_BUF0_PTR, 32'h0);
    chkb("trap", 1'h1, illegal_opcode_trap);
    chkb("acc_valid", 1'h0, acc_result_valid);
    final_report();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #20_000;
    err_total++;
    final_report();
  end
endmodule
